// File: core/serial_host_map.svh
`ifndef SERIAL_HOST_MAP_SVH
`define SERIAL_HOST_MAP_SVH

// ==========================================
// register offsets (byte addresses)
`define OFS_CONTROL_STATUS   4'h0
`define OFS_TRANSMIT_DATA    4'h4

// ==========================================
// control field positions
`define BIT_PORT_ENABLE      0
`define BIT_PROTOCOL_SELECT  1
`define BIT_WORD_SIZE_LO     2
`define BIT_WORD_SIZE_HI     3
`define BIT_CLOCK_FREEZE     4
`define BIT_DEPTH_SELECT     5
`define BIT_MASTER_SELECT    6
`define BIT_REQ_ENABLE_LO    7
`define BIT_REQ_ENABLE_HI    8
`define BIT_MASTER_IDLE      9
`define BIT_BUS_ERR_IE       10
`define BIT_TRANSMIT_IE      11
`define BIT_RECEIVE_IE_LO    12
`define BIT_RECEIVE_IE_HI    13

// ==========================================
// status field positions
`define BIT_TX_UNDERRUN      14
`define BIT_TX_EMPTY         15
`define BIT_RX_NOT_EMPTY     17
`define BIT_RX_FULL          19
`define BIT_RX_OVERRUN       20
`define BIT_BUS_ERROR        21
`define BIT_PORT_BUSY        22

// ==========================================
// reset values and sizes
`define CONTROL_RESET        14'h0200
`define WORD_BITS_8          5'h08
`define WORD_BITS_16         5'h10
`define WORD_BITS_24         5'h18
`define DEPTH_SINGLE         4'h1
`define DEPTH_DEEP           4'hA
`define MASK_DELAY_CYCLES    1

`endif

// File: core/serial_host_pkg.sv
`default_nettype none

package serial_host_pkg;

    typedef enum logic [1:0] {
        WS_8        = 2'b00,
        WS_16       = 2'b01,
        WS_24       = 2'b10,
        WS_RESERVED = 2'b11
    } word_size_t;

    typedef enum logic [1:0] {
        RXI_OFF      = 2'b00,
        RXI_NOT_EMPTY = 2'b01,
        RXI_RESERVED = 2'b10,
        RXI_FULL     = 2'b11
    } rx_irq_mode_t;

endpackage

`default_nettype wire

// File: core/serial_host_control_status.sv
// Behaviour
// RQ1 - protocol bit: zero SPI, one I2C
// RQ2 - word size 8/16/24 bits, 11 reserved
// RQ3 - software changes size/request fields only idle
// RQ4 - I2C slave freeze holds SCL, else error
// RQ5 - freeze transmit needs matched internal clock rate
// RQ6 - depth bit: one level or ten levels
// RQ7 - software disables port before mode changes
// RQ8 - master bit selects master or slave role
// RQ9 - slave select in SPI master sets error
// RQ10 - request pin: off, or master clock pause input
// RQ11 - slave request pin shows shifter readiness
// RQ12 - idle set by control write, cleared by transmit
// RQ13 - transmit write while idle sends restart address
// RQ14 - word end without data: stall or stop
// RQ15 - receive ack follows idle; idle stops after word
// RQ16 - receive full stalls clock before ack
// RQ17 - idle reads set outside I2C master, resets
// RQ18 - bus error interrupt when enabled and flagged
// RQ19 - transmit and underrun interrupt requests
// RQ20 - receive interrupt modes per enable field
// RQ21 - cleared enable masks after one cycle
// RQ22 - bits 23, 18, 16 read zero
// RQ23 - enable clear enters individual reset next cycle
// RQ24 - reserved encodings handled safely
`timescale 1ns/100ps
`default_nettype none
`include "serial_host_map.svh"

module serial_host_control_status (
    input  wire logic                          CORE_CLK_I,
    input  wire logic                          RST_B_I,
    input  wire logic [3:0]                    AVS_ADDRESS_I,
    input  wire logic                          AVS_READ_I,
    input  wire logic                          AVS_WRITE_I,
    input  wire logic [31:0]                   AVS_WRITEDATA_I,
    output logic [31:0]                        AVS_READDATA_O,
    output logic                               AVS_WAITREQUEST_O,
    input  wire logic                          SOFT_RESET_I,
    input  wire logic                          STOP_STATE_I,
    input  wire logic                          PORT_BUSY_I,
    input  wire logic                          TX_EMPTY_I,
    input  wire logic                          TX_UNDERRUN_I,
    input  wire logic                          RX_NOT_EMPTY_I,
    input  wire logic                          RX_FULL_I,
    input  wire logic                          RX_OVERRUN_I,
    input  wire logic                          SHIFT_RX_READY_I,
    input  wire logic                          SHIFT_TX_READY_I,
    input  wire logic                          SLAVE_READING_I,
    input  wire logic                          SLAVE_WORD_START_I,
    input  wire logic                          TX_WORD_DONE_I,
    input  wire logic                          RX_WORD_DONE_I,
    input  wire logic                          SCL_I,
    input  wire logic                          SS_B_I,
    input  wire logic                          REQ_PIN_I,
    output logic                               REQ_PIN_O,
    output logic                               REQ_PIN_OE_O,
    output logic                               PORT_ACTIVE_O,
    output logic                               PROTO_I2C_O,
    output logic                               MASTER_O,
    output serial_host_pkg::word_size_t        WORD_SIZE_O,
    output logic [4:0]                         WORD_BITS_O,
    output logic [3:0]                         RX_DEPTH_O,
    output logic                               SERIAL_PAUSE_O,
    output logic                               SCL_HOLD_O,
    output logic                               SLAVE_UNDERRUN_O,
    output logic                               SLAVE_OVERRUN_O,
    output logic [23:0]                        TX_DATA_O,
    output logic                               TX_WRITE_O,
    output logic                               RESTART_ADDR_O,
    output logic                               STOP_REQ_O,
    output logic                               CLOCK_STALL_O,
    output logic                               ACK_BIT_O,
    output logic                               IRQ_BUS_ERR_O,
    output logic                               IRQ_TX_DATA_O,
    output logic                               IRQ_TX_UNDERRUN_O,
    output logic                               IRQ_RX_DATA_O,
    output logic                               IRQ_RX_OVERRUN_O
);
    import serial_host_pkg::*;

    // ==========================================
    // bus slave
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic        wr_csr;
    logic        wr_tx;
    logic [31:0] rd_next;
    logic [13:0] ctrl_reg;
    logic        active_reg;
    logic        bus_err_reg;
    logic        i2c_master;
    logic        idle_view;

    // a request is served on the edge after it is seen with wait low
    assign wr_csr = AVS_WRITE_I && !wait_reg && AVS_ADDRESS_I == `OFS_CONTROL_STATUS;
    assign wr_tx  = AVS_WRITE_I && !wait_reg && AVS_ADDRESS_I == `OFS_TRANSMIT_DATA;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !(wait_reg && (AVS_READ_I || AVS_WRITE_I));
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        if (AVS_ADDRESS_I == `OFS_CONTROL_STATUS) begin
            rd_next[13:0]               = ctrl_reg;
            rd_next[`BIT_MASTER_IDLE]   = idle_view;      // [RQ17]
            rd_next[`BIT_TX_UNDERRUN]   = active_reg && TX_UNDERRUN_I;
            rd_next[`BIT_TX_EMPTY]      = !active_reg || TX_EMPTY_I;
            rd_next[`BIT_RX_NOT_EMPTY]  = active_reg && RX_NOT_EMPTY_I;
            rd_next[`BIT_RX_FULL]       = active_reg && RX_FULL_I;
            rd_next[`BIT_RX_OVERRUN]    = active_reg && RX_OVERRUN_I;
            rd_next[`BIT_BUS_ERROR]     = bus_err_reg;
            rd_next[`BIT_PORT_BUSY]     = active_reg && PORT_BUSY_I;
            // bits 23, 18 and 16 stay zero [RQ22]
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rdata_reg <= 32'h0000_0000;
        end else if (wait_reg && AVS_READ_I) begin
            rdata_reg <= rd_next;
        end
    end

    assign AVS_WAITREQUEST_O = wait_reg;
    assign AVS_READDATA_O    = rdata_reg;

    // ==========================================
    // control register
    logic idle_reg;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl_reg <= `CONTROL_RESET;
        end else if (SOFT_RESET_I) begin
            ctrl_reg <= `CONTROL_RESET;
        end else if (wr_csr) begin
            ctrl_reg <= AVS_WRITEDATA_I[13:0];
        end
    end

    assign i2c_master = active_reg && ctrl_reg[`BIT_PROTOCOL_SELECT] && ctrl_reg[`BIT_MASTER_SELECT];
    assign idle_view  = idle_reg || !i2c_master;

    // idle is set by control writes with bit 9 set and by soft reset, stop or a disabled port; only a transmit write clears it
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            idle_reg <= 1'b1;
        end else if (SOFT_RESET_I || STOP_STATE_I || !active_reg) begin
            idle_reg <= 1'b1;                                      // [RQ17]
        end else if (wr_csr && AVS_WRITEDATA_I[`BIT_MASTER_IDLE]) begin
            idle_reg <= 1'b1;                                      // [RQ12]
        end else if (wr_tx) begin
            idle_reg <= 1'b0;                                      // [RQ12]
        end
    end

    // individual reset follows a cleared enable by one cycle
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= ctrl_reg[`BIT_PORT_ENABLE] && !SOFT_RESET_I && !STOP_STATE_I; // [RQ23]
        end
    end

    // ==========================================
    // configuration outputs
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            PORT_ACTIVE_O <= 1'b0;
            PROTO_I2C_O   <= 1'b0;
            MASTER_O      <= 1'b0;
            WORD_SIZE_O   <= WS_8;
            WORD_BITS_O   <= `WORD_BITS_8;
            RX_DEPTH_O    <= `DEPTH_SINGLE;
        end else begin
            PORT_ACTIVE_O <= active_reg;                                         // [RQ23]
            PROTO_I2C_O   <= ctrl_reg[`BIT_PROTOCOL_SELECT];                     // [RQ1]
            MASTER_O      <= ctrl_reg[`BIT_MASTER_SELECT];                       // [RQ8]
            WORD_SIZE_O   <= word_size_t'(ctrl_reg[`BIT_WORD_SIZE_HI:`BIT_WORD_SIZE_LO]);
            RX_DEPTH_O    <= ctrl_reg[`BIT_DEPTH_SELECT] ? `DEPTH_DEEP : `DEPTH_SINGLE; // [RQ6]
            unique case (word_size_t'(ctrl_reg[`BIT_WORD_SIZE_HI:`BIT_WORD_SIZE_LO]))
                WS_8:        WORD_BITS_O <= `WORD_BITS_8;                        // [RQ2]
                WS_16:       WORD_BITS_O <= `WORD_BITS_16;                       // [RQ2]
                WS_24:       WORD_BITS_O <= `WORD_BITS_24;                       // [RQ2]
                WS_RESERVED: WORD_BITS_O <= `WORD_BITS_8;                        // [RQ24]
            endcase
        end
    end

    // ==========================================
    // pin synchronisers: scl, slave select, request
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       scl_prev_reg;
    logic       scl_fall;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            sync1_reg    <= 3'h7;
            sync2_reg    <= 3'h7;
            scl_prev_reg <= 1'b1;
        end else begin
            sync1_reg    <= {REQ_PIN_I, SS_B_I, SCL_I};
            sync2_reg    <= sync1_reg;
            scl_prev_reg <= sync2_reg[0];
        end
    end

    assign scl_fall = scl_prev_reg && !sync2_reg[0];

    // ==========================================
    // bus error from slave select in SPI master
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            bus_err_reg <= 1'b0;
        end else if (!active_reg) begin
            bus_err_reg <= 1'b0;                                   // [RQ23]
        end else if (!ctrl_reg[`BIT_PROTOCOL_SELECT] && ctrl_reg[`BIT_MASTER_SELECT]
                     && !sync2_reg[1]) begin
            bus_err_reg <= 1'b1;                                   // [RQ9]
        end
    end

    // ==========================================
    // request pin, driven low when asserted; as master input, a high pin pauses
    logic [1:0] rqe;
    logic       req_assert;

    assign rqe = ctrl_reg[`BIT_REQ_ENABLE_HI:`BIT_REQ_ENABLE_LO];

    always_comb begin
        unique case (rqe)
            2'b01:   req_assert = SHIFT_RX_READY_I;                                // [RQ11]
            2'b10:   req_assert = SHIFT_TX_READY_I;                                // [RQ11]
            2'b11:   req_assert = ctrl_reg[`BIT_PROTOCOL_SELECT]
                                ? (SHIFT_RX_READY_I || SHIFT_TX_READY_I)
                                : (SHIFT_RX_READY_I && SHIFT_TX_READY_I);          // [RQ11]
            default: req_assert = 1'b0;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            REQ_PIN_O      <= 1'b1;
            REQ_PIN_OE_O   <= 1'b0;
            SERIAL_PAUSE_O <= 1'b0;
        end else begin
            REQ_PIN_O      <= !req_assert;
            REQ_PIN_OE_O   <= active_reg && rqe != 2'b00 && !ctrl_reg[`BIT_MASTER_SELECT]; // [RQ10]
            SERIAL_PAUSE_O <= active_reg && rqe != 2'b00 && ctrl_reg[`BIT_MASTER_SELECT]
                              && sync2_reg[2];                                     // [RQ10]
        end
    end

    // ==========================================
    // I2C slave clock freeze
    logic slave_mode;
    logic word_pend_reg;
    logic not_ready;

    assign slave_mode = active_reg && ctrl_reg[`BIT_PROTOCOL_SELECT] && !ctrl_reg[`BIT_MASTER_SELECT];
    assign not_ready  = SLAVE_READING_I ? !SHIFT_TX_READY_I : RX_FULL_I;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            word_pend_reg    <= 1'b0;
            SCL_HOLD_O       <= 1'b0;
            SLAVE_UNDERRUN_O <= 1'b0;
            SLAVE_OVERRUN_O  <= 1'b0;
        end else begin
            SLAVE_UNDERRUN_O <= 1'b0;
            SLAVE_OVERRUN_O  <= 1'b0;
            if (!slave_mode) begin
                word_pend_reg <= 1'b0;
                SCL_HOLD_O    <= 1'b0;
            end else if (SLAVE_WORD_START_I) begin
                word_pend_reg <= 1'b1;
            end else if (word_pend_reg && (scl_fall || SCL_HOLD_O)) begin
                if (not_ready && ctrl_reg[`BIT_CLOCK_FREEZE]) begin
                    SCL_HOLD_O <= 1'b1;                            // [RQ4]
                end else begin
                    SCL_HOLD_O       <= 1'b0;
                    word_pend_reg    <= 1'b0;
                    SLAVE_UNDERRUN_O <= not_ready && SLAVE_READING_I;   // [RQ4]
                    SLAVE_OVERRUN_O  <= not_ready && !SLAVE_READING_I;  // [RQ4]
                end
            end
        end
    end

    // ==========================================
    // I2C master idle, stop, stall and acknowledge
    logic stall_tx_reg;
    logic stall_rx_reg;
    logic tx_stall_set;
    logic rx_stall_set;

    assign tx_stall_set = i2c_master && TX_WORD_DONE_I && TX_EMPTY_I && !idle_reg;
    assign rx_stall_set = i2c_master && RX_WORD_DONE_I && RX_FULL_I;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            stall_tx_reg <= 1'b0;
            stall_rx_reg <= 1'b0;
        end else begin
            stall_tx_reg <= tx_stall_set || (stall_tx_reg && i2c_master && !wr_tx
                            && !idle_reg);                                          // [RQ14]
            stall_rx_reg <= rx_stall_set || (stall_rx_reg && i2c_master && RX_FULL_I); // [RQ16]
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            TX_DATA_O      <= 24'h00_0000;
            TX_WRITE_O     <= 1'b0;
            RESTART_ADDR_O <= 1'b0;
            STOP_REQ_O     <= 1'b0;
            CLOCK_STALL_O  <= 1'b0;
            ACK_BIT_O      <= 1'b1;
        end else begin
            TX_WRITE_O     <= wr_tx;
            RESTART_ADDR_O <= wr_tx && i2c_master && idle_reg;                      // [RQ13]
            STOP_REQ_O     <= i2c_master && idle_reg
                              && ((TX_WORD_DONE_I && TX_EMPTY_I) || RX_WORD_DONE_I); // [RQ14] [RQ15]
            CLOCK_STALL_O  <= tx_stall_set || rx_stall_set
                              || (stall_tx_reg && i2c_master && !wr_tx && !idle_reg)
                              || (stall_rx_reg && i2c_master && RX_FULL_I);         // [RQ16]
            ACK_BIT_O      <= idle_view;                                            // [RQ15]
            if (wr_tx) begin
                TX_DATA_O <= AVS_WRITEDATA_I[23:0];                                 // [RQ13]
            end
        end
    end

    // ==========================================
    // interrupt requests with one cycle mask delay
    logic [3:0] ie_dly_reg;
    logic [3:0] ie_eff;
    logic       rx_on;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ie_dly_reg <= 4'h0;
        end else begin
            ie_dly_reg <= ctrl_reg[`BIT_RECEIVE_IE_HI:`BIT_BUS_ERR_IE];
        end
    end

    assign ie_eff = ctrl_reg[`BIT_RECEIVE_IE_HI:`BIT_BUS_ERR_IE] | ie_dly_reg;    // [RQ21]
    assign rx_on  = ie_eff[3:2] == RXI_NOT_EMPTY || ie_eff[3:2] == RXI_FULL;      // [RQ24]

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            IRQ_BUS_ERR_O     <= 1'b0;
            IRQ_TX_DATA_O     <= 1'b0;
            IRQ_TX_UNDERRUN_O <= 1'b0;
            IRQ_RX_DATA_O     <= 1'b0;
            IRQ_RX_OVERRUN_O  <= 1'b0;
        end else begin
            IRQ_BUS_ERR_O     <= ie_eff[0] && bus_err_reg;                          // [RQ18]
            IRQ_TX_DATA_O     <= ie_eff[1] && active_reg && TX_EMPTY_I && !TX_UNDERRUN_I; // [RQ19]
            IRQ_TX_UNDERRUN_O <= ie_eff[1] && active_reg && TX_UNDERRUN_I;          // [RQ19]
            IRQ_RX_OVERRUN_O  <= rx_on && active_reg && RX_OVERRUN_I;               // [RQ20]
            IRQ_RX_DATA_O     <= rx_on && active_reg && !RX_OVERRUN_I
                                 && (ie_eff[3] ? RX_FULL_I : RX_NOT_EMPTY_I);       // [RQ20]
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);

    sequence s_ber_enable_cleared;
        $fell(ctrl_reg[`BIT_BUS_ERR_IE]) && bus_err_reg && !SOFT_RESET_I;
    endsequence

    // request still out one edge after the clear, gone the edge after
    sequence s_ber_masked_late;
        IRQ_BUS_ERR_O ##1 (!IRQ_BUS_ERR_O || ctrl_reg[`BIT_BUS_ERR_IE]);
    endsequence

    AST_BUS_ERR_MASK_DELAY: assert property ( // [RQ21]
        s_ber_enable_cleared |=> s_ber_masked_late
    ) else $error("bus error mask delay wrong");
    AST_BUS_ERR_IRQ: assert property ( // [RQ18]
        ctrl_reg[`BIT_BUS_ERR_IE] && bus_err_reg |=> IRQ_BUS_ERR_O
    ) else $error("bus error request missing");
    AST_SS_BUS_ERROR: assert property ( // [RQ9]
        active_reg && !ctrl_reg[`BIT_PROTOCOL_SELECT] && ctrl_reg[`BIT_MASTER_SELECT]
        && !sync2_reg[1] |=> bus_err_reg
    ) else $error("slave select did not flag bus error");
    AST_IDLE_OUTSIDE_MASTER: assert property ( // [RQ17]
        !i2c_master && wait_reg && AVS_READ_I && AVS_ADDRESS_I == `OFS_CONTROL_STATUS
        |=> AVS_READDATA_O[`BIT_MASTER_IDLE]
    ) else $error("idle read clear outside I2C master");
    AST_TX_CLEARS_IDLE: assert property ( // [RQ12]
        wr_tx && active_reg && !SOFT_RESET_I && !STOP_STATE_I |=> !idle_reg
    ) else $error("transmit write left idle set");
    AST_RESTART_ADDR: assert property ( // [RQ13]
        wr_tx && i2c_master && idle_reg |=> RESTART_ADDR_O && TX_WRITE_O
    ) else $error("restart address not requested");
    AST_IND_RESET: assert property ( // [RQ23]
        !ctrl_reg[`BIT_PORT_ENABLE] ##1 !ctrl_reg[`BIT_PORT_ENABLE] |=> !REQ_PIN_OE_O
        && !bus_err_reg && !PORT_ACTIVE_O
    ) else $error("individual reset not entered");
    AST_RX_RESERVED: assert property ( // [RQ24]
        ctrl_reg[`BIT_RECEIVE_IE_HI:`BIT_RECEIVE_IE_LO] == RXI_RESERVED
        && $stable(ctrl_reg) |=> !IRQ_RX_DATA_O && !IRQ_RX_OVERRUN_O
    ) else $error("reserved receive enable raised a request");
    AST_RX_FULL_STALL: assert property ( // [RQ16]
        rx_stall_set |=> CLOCK_STALL_O ##1 (CLOCK_STALL_O || !RX_FULL_I || !i2c_master)
    ) else $error("no stall on full receive");
    AST_ACK_FOLLOWS_IDLE: assert property ( // [RQ15]
        i2c_master && $stable(idle_reg) |=> ACK_BIT_O == $past(idle_reg)
    ) else $error("acknowledge bit does not follow idle");

endmodule

`default_nettype wire

// File: testbench/serial_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module serial_far_end (
    input  wire logic frame_i,
    input  wire logic sel_i,
    input  wire logic hold_i,
    output logic      scl_o,
    output logic      ss_b_o,
    output logic      req_b_o
);
    // ==========
    // link clock runs only inside a frame, pulled high otherwise
    // fixed rate, the one the port's own generator is set to match
    initial begin
        scl_o = 1'b1;
        forever #62.5 scl_o = frame_i ? ~scl_o : 1'b1;
    end
    // select stays high unless a fault is commanded
    assign ss_b_o = ~sel_i;
    // request line high pauses a master's clock
    assign req_b_o = ~hold_i;
endmodule
`default_nettype wire

// File: testbench/serial_host_control_status_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_host_control_status_tb;
// ==========
// wiring
logic clk, rst_b, rd, wr, wq, reqo, oe, pause, rs, stall, ack, ibe, irx;
logic fr, sel, hold, req_b, req_w, scl, ss_b, stp, frz, pa, pi, ms, itx, itu, iro;
logic [1:0] ws;
logic [3:0] adr, dep;
logic [4:0] wb;
logic [13:0] s;
logic [23:0] txd;
logic [31:0] wd, rdat, q;
int err_count, tests_run;
assign req_w = oe ? reqo : req_b;
serial_far_end far_u (.frame_i(fr), .sel_i(sel), .hold_i(hold), .scl_o(scl), .ss_b_o(ss_b),
    .req_b_o(req_b));
serial_host_control_status dut_u (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq),
    .SOFT_RESET_I(s[0]), .STOP_STATE_I(s[1]), .PORT_BUSY_I(s[2]), .TX_EMPTY_I(s[3]),
    .TX_UNDERRUN_I(s[4]), .RX_NOT_EMPTY_I(s[5]), .RX_FULL_I(s[6]), .RX_OVERRUN_I(s[7]),
    .SHIFT_RX_READY_I(s[8]), .SHIFT_TX_READY_I(s[9]), .SLAVE_READING_I(s[10]),
    .SLAVE_WORD_START_I(s[11]), .TX_WORD_DONE_I(s[12]), .RX_WORD_DONE_I(s[13]),
    .SCL_I(scl), .SS_B_I(ss_b), .REQ_PIN_I(req_w), .REQ_PIN_O(reqo), .REQ_PIN_OE_O(oe),
    .PORT_ACTIVE_O(pa), .PROTO_I2C_O(pi), .MASTER_O(ms), .WORD_SIZE_O(ws), .WORD_BITS_O(wb),
    .RX_DEPTH_O(dep), .SERIAL_PAUSE_O(pause), .SCL_HOLD_O(frz), .SLAVE_UNDERRUN_O(),
    .SLAVE_OVERRUN_O(), .TX_DATA_O(txd), .TX_WRITE_O(), .RESTART_ADDR_O(rs),
    .STOP_REQ_O(stp), .CLOCK_STALL_O(stall), .ACK_BIT_O(ack), .IRQ_BUS_ERR_O(ibe),
    .IRQ_TX_DATA_O(itx), .IRQ_TX_UNDERRUN_O(itu), .IRQ_RX_DATA_O(irx), .IRQ_RX_OVERRUN_O(iro));
// ==========
// tasks
task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
endtask
// port parked in individual reset while its mode changes
task automatic cfg(input logic [31:0] d);
    bus(0, 0, 0);
    bus(1, 0, q & 32'h0000_3DFE);
    bus(1, 0, d & 32'h0000_3FFE);
    bus(1, 0, d);
endtask
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
        err_count++;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
endtask
task automatic print_verdict;
    $display("mismatches %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
end
initial begin
    #50000;
    err_count++;
    print_verdict;
end
// ==========
// sequence
initial begin
    {rst_b, rd, wr, fr, sel, hold, s, adr, wd} <= '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, 0, 0);
    chk(q, 32'h0000_8200);
    s <= 14'h00FC;
    bus(1, 0, 32'h00FF_FFFF);
    bus(0, 0, 0);
    chk(q, 32'h005A_FFFF);
    chk({27'h0, wb}, 8);
    chk({23'h0, pa, pi, ms, ws, ibe, itx, itu, iro}, 9'h1F3);
    bus(1, 0, 32'h0000_3FFE);
    for (int i = 0; i < 4; i++) begin
        bus(1, 0, {26'h0, i[0], 1'b0, i[1:0], 2'b00});
        repeat (2) @(posedge clk);
        chk({27'h0, wb}, i == 1 ? 16 : i == 2 ? 24 : 8);
        chk({28'h0, dep}, i[0] ? 10 : 1);
    end
    s <= 14'h0020;
    for (int m = 0; m < 4; m++) begin
        bus(1, 0, {18'h0, m[1:0], 12'h001});
        repeat (3) @(posedge clk);
        chk({31'h0, irx}, m == 1);
    end
    cfg(32'h0000_0441);
    sel <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, ibe}, 1);
    sel <= 1'b0;
    bus(1, 0, 32'h0000_0041);
    repeat (3) @(posedge clk);
    chk({31'h0, ibe}, 0);
    s <= 14'h0008;
    fr <= 1'b1;
    cfg(32'h0000_0243);
    chk({31'h0, ack}, 1);
    bus(1, 4, 32'h00AB_CDEF);
    @(posedge clk);
    chk({31'h0, rs}, 1);
    @(posedge clk);
    chk({8'h0, txd}, 32'h00AB_CDEF);
    chk({31'h0, ack}, 0);
    bus(0, 0, 0);
    chk({31'h0, q[9]}, 0);
    s[12] <= 1'b1;
    @(posedge clk);
    s[12] <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, stall}, 1);
    bus(1, 4, 32'h0000_0012);
    repeat (2) @(posedge clk);
    chk({31'h0, stall}, 0);
    s <= 14'h2048;
    @(posedge clk);
    s <= 14'h0048;
    repeat (2) @(posedge clk);
    chk({31'h0, stall}, 1);
    s <= 14'h0008;
    repeat (2) @(posedge clk);
    chk({31'h0, stall}, 0);
    bus(1, 0, 32'h0000_0243);
    s[12] <= 1'b1;
    @(posedge clk);
    s[12] <= 1'b0;
    @(posedge clk);
    chk({30'h0, stp, stall}, 2'b10);
    chk({31'h0, ack}, 1);
    cfg(32'h0000_0013);
    @(posedge clk);
    s <= 14'h0C00;
    @(posedge clk);
    s <= 14'h0400;
    repeat (40) @(posedge clk);
    chk({31'h0, frz}, 1);
    s <= 14'h0600;
    repeat (2) @(posedge clk);
    chk({31'h0, frz}, 0);
    fr <= 1'b0;
    s <= 14'h0100;
    cfg(32'h0000_0081);
    repeat (3) @(posedge clk);
    chk({30'h0, oe, reqo}, 2'b10);
    bus(1, 0, 32'h0000_0101);
    repeat (3) @(posedge clk);
    chk({30'h0, oe, reqo}, 2'b11);
    cfg(32'h0000_00C1);
    repeat (5) @(posedge clk);
    chk({30'h0, oe, pause}, 2'b01);
    hold <= 1'b1;
    repeat (5) @(posedge clk);
    chk({31'h0, pause}, 0);
    print_verdict;
end
endmodule
`default_nettype wire
